// file: hw/ctm_params.svh
// Constants for the counter time measurement block.
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH

// Count register width and its fixed values.
`define CTM_CNT_W      24
`define CTM_ZERO_CNT   24'h000000
`define CTM_ONE_CNT    24'h000001
`define CTM_MAX_CNT    24'hFFFFFF

// Divisor exponent width and divider counter width.
`define CTM_DIV_W      4
`define CTM_DIVC_W     16
`define CTM_DIVC_ZERO  16'h0000
`define CTM_DIVC_ONE   16'h0001
`define CTM_DIVC_ALL   16'hFFFF

// Result buffer depth.
`define CTM_FIFO_DEPTH 16

`endif

// file: hw/ctm_pkg.sv
// Types shared by the counter time measurement block.
`default_nettype none

package ctm_pkg;

	// Counter application selected by the host.
	typedef enum logic [2:0] {
		MODE_PULSE_GEN,
		MODE_ONE_CTR_TIME,
		MODE_TWO_CTR_TIME,
		MODE_EDGE_UNBUF,
		MODE_EDGE_BUF,
		MODE_TWO_EDGE_SEP,
		MODE_POSITION
	} ctm_mode_t;

	// How results reach the host.
	typedef enum logic [1:0] {
		TIMING_IMPLICIT,
		TIMING_SAMPLE_CLK,
		TIMING_ON_DEMAND
	} ctm_timing_t;

	// Configuration word, held stable while armed.
	typedef struct packed {
		ctm_mode_t   mode;
		ctm_timing_t timing;
		logic        pulse_train;
		logic        out_toggle;
		logic        gate_start;
		logic        dir_from_aux;
		logic        z_enable;
		logic        large_range;
		logic [3:0]  div_log2;
		logic [23:0] load;
	} ctm_cfg_t;

endpackage

`default_nettype wire

// file: hw/ctm_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none

module ctm_sync (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_pin,
	output var  logic o_level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// The first stage feeds only the second, so metastability stays contained.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A change counts only once the second and third stages agree.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_level <= 1'b0;
		else if (s2_reg == s3_reg)
			o_level <= s3_reg;
	end

endmodule

`default_nettype wire

// file: hw/ctm_fifo.sv
// Result FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module ctm_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;
	logic             do_wr;
	logic             do_rd;

	// Extra pointer bit tells full from empty.
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign o_in_ready = ~full;
	assign o_out_valid = ~empty;
	assign do_wr = i_in_valid & ~full;
	assign do_rd = i_out_ready & ~empty;
	assign o_out_data = mem[rd_ptr_reg[AW-1:0]];

	// Storage write.
	always_ff @(posedge i_clk)
	begin
		if (do_wr)
			mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
	end

	// Pointer update.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_rd)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule

`default_nettype wire

// file: hw/ctm_top.sv
// Counter for time measurement, edge counting, position and pulse output.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_params.svh"

module ctm_top (
	input  wire logic                   i_clk,
	input  wire logic                   i_sys_rst,
	input  wire ctm_pkg::ctm_cfg_t      i_cfg,
	input  wire logic                   i_arm,
	input  wire logic                   i_export,
	input  wire logic                   i_tristate,
	input  wire logic                   i_read_req,
	input  wire logic                   i_count_control_input,
	input  wire logic                   i_count_edge_input,
	input  wire logic                   i_auxiliary_count_input,
	input  wire logic                   i_sample_clock_input,
	output logic     [`CTM_CNT_W-1:0]   o_count,
	output logic                        o_counter_event_output,
	output logic                        o_connector_counter_pin,
	output logic                        o_connector_counter_pin_oe,
	output logic                        o_read_valid,
	output logic     [`CTM_CNT_W-1:0]   o_read_data,
	output logic                        o_res_valid,
	input  wire logic                   i_res_ready,
	output logic     [`CTM_CNT_W-1:0]   o_res_data
);

	// ****************************************************************
	// Input conditioning
	// ****************************************************************

	logic gate_lvl;
	logic src_lvl;
	logic aux_lvl;
	logic smp_lvl;
	logic gate_d_reg;
	logic src_d_reg;
	logic aux_d_reg;
	logic smp_d_reg;
	logic gate_rise;
	logic src_rise;
	logic aux_rise;
	logic smp_rise;

	ctm_sync u_sync_gate (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_pin(i_count_control_input), .o_level(gate_lvl));
	ctm_sync u_sync_src (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_pin(i_count_edge_input), .o_level(src_lvl));
	ctm_sync u_sync_aux (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_pin(i_auxiliary_count_input), .o_level(aux_lvl));
	ctm_sync u_sync_smp (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_pin(i_sample_clock_input), .o_level(smp_lvl));

	// Previous filtered levels for rising-edge detection.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			gate_d_reg <= 1'b0;
			src_d_reg <= 1'b0;
			aux_d_reg <= 1'b0;
			smp_d_reg <= 1'b0;
		end
		else
		begin
			gate_d_reg <= gate_lvl;
			src_d_reg <= src_lvl;
			aux_d_reg <= aux_lvl;
			smp_d_reg <= smp_lvl;
		end
	end

	assign gate_rise = gate_lvl & ~gate_d_reg;
	assign src_rise = src_lvl & ~src_d_reg;
	assign aux_rise = aux_lvl & ~aux_d_reg;
	assign smp_rise = smp_lvl & ~smp_d_reg;

	// ****************************************************************
	// Counting core
	// ****************************************************************

	logic [`CTM_CNT_W-1:0]  cnt_reg;
	logic [`CTM_CNT_W-1:0]  cnt_next;
	logic [`CTM_DIVC_W-1:0] div_reg;
	logic [`CTM_DIVC_W-1:0] div_mask;
	logic                   started_reg;
	logic                   started_next;
	logic                   done_reg;
	logic                   done_next;
	logic                   first_reg;
	logic                   tc;
	logic                   mark;
	logic                   tick;
	logic                   up;
	logic                   div_done;
	logic                   stall;
	logic                   demand;
	logic [`CTM_CNT_W-1:0]  meas_val;

	assign demand = (i_cfg.timing == ctm_pkg::TIMING_ON_DEMAND);
	// Divisor is a power of two so the period scales back by a shift.
	assign div_mask = i_cfg.large_range ?
		~(`CTM_DIVC_ALL << i_cfg.div_log2) : `CTM_DIVC_ZERO;
	assign div_done = src_rise && ((div_reg & div_mask) == div_mask);
	// Reported period is the measured span shifted down by the divisor.
	assign meas_val = (i_cfg.mode == ctm_pkg::MODE_TWO_CTR_TIME && i_cfg.large_range) ?
		(cnt_reg >> i_cfg.div_log2) : cnt_reg;
	assign up = i_cfg.dir_from_aux ? aux_lvl : 1'b1;

	// Per-mode roles of the three inputs and the next count.
	always_comb
	begin
		cnt_next = cnt_reg;
		started_next = started_reg;
		done_next = done_reg;
		tc = 1'b0;
		mark = 1'b0;
		tick = 1'b0;
		case (i_cfg.mode)
			ctm_pkg::MODE_PULSE_GEN:
			begin
				// Gate starts or pauses; the edge input is the timebase.
				if (gate_rise)
					started_next = 1'b1;
				if (!done_reg && src_rise && (i_cfg.gate_start ? started_reg : gate_lvl))
				begin
					if (cnt_reg == `CTM_ZERO_CNT)
					begin
						tc = 1'b1;
						// A train reloads; a single pulse stops here.
						if (i_cfg.pulse_train)
							cnt_next = i_cfg.load;
						else
							done_next = 1'b1;
					end
					else
						cnt_next = cnt_reg - `CTM_ONE_CNT;
				end
			end
			ctm_pkg::MODE_EDGE_UNBUF, ctm_pkg::MODE_EDGE_BUF:
			begin
				// Edge input is counted; gate pauses or samples.
				mark = (i_cfg.mode == ctm_pkg::MODE_EDGE_BUF) && gate_rise;
				if (src_rise && (i_cfg.mode == ctm_pkg::MODE_EDGE_BUF || gate_lvl))
				begin
					if (up)
					begin
						cnt_next = cnt_reg + `CTM_ONE_CNT;
						tc = (cnt_reg == `CTM_MAX_CNT);
					end
					else if (cnt_reg != `CTM_ZERO_CNT)
					begin
						cnt_next = cnt_reg - `CTM_ONE_CNT;
						tc = (cnt_reg == `CTM_ONE_CNT);
					end
				end
			end
			ctm_pkg::MODE_POSITION:
			begin
				// Edge input is A, auxiliary is B, gate is the index.
				if (i_cfg.z_enable && gate_rise)
					cnt_next = `CTM_ZERO_CNT;
				else if (src_rise)
					cnt_next = aux_lvl ? cnt_reg - `CTM_ONE_CNT : cnt_reg + `CTM_ONE_CNT;
			end
			default:
			begin
				// Time measurements: pick the timebase and the closing edge.
				if (i_cfg.mode == ctm_pkg::MODE_ONE_CTR_TIME)
				begin
					tick = src_rise;
					mark = gate_rise;
				end
				else if (i_cfg.mode == ctm_pkg::MODE_TWO_CTR_TIME)
				begin
					// The system clock is the timebase; the edge input is measured.
					tick = 1'b1;
					mark = div_done;
				end
				else
				begin
					// Auxiliary opens the interval, gate closes it.
					tick = src_rise && started_reg;
					mark = gate_rise && started_reg;
					if (aux_rise)
						started_next = 1'b1;
					else if (mark)
						started_next = 1'b0;
				end
				if (mark || (i_cfg.mode == ctm_pkg::MODE_TWO_EDGE_SEP && aux_rise))
					cnt_next = `CTM_ZERO_CNT;
				else if (tick)
				begin
					cnt_next = cnt_reg + `CTM_ONE_CNT;
					tc = (cnt_reg == `CTM_MAX_CNT);
				end
			end
		endcase
	end

	// Count register: cleared by reset, preloaded while disarmed.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			cnt_reg <= `CTM_ZERO_CNT;
		else if (!i_arm)
			cnt_reg <= i_cfg.load;
		else if (demand && i_read_req && i_cfg.mode != ctm_pkg::MODE_POSITION)
			cnt_reg <= `CTM_ZERO_CNT;
		else if (!stall)
			cnt_reg <= cnt_next;
	end

	// Sequence flags and the large-range divider.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !i_arm)
		begin
			started_reg <= 1'b0;
			done_reg <= 1'b0;
			div_reg <= `CTM_DIVC_ZERO;
		end
		else if (!stall)
		begin
			started_reg <= started_next;
			done_reg <= done_next;
			if (src_rise)
				div_reg <= div_reg + `CTM_DIVC_ONE;
		end
	end

	// First interval after arming or a read may be partial.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !i_arm)
			first_reg <= 1'b1;
		else if (demand && i_read_req)
			first_reg <= 1'b1;
		else if (mark && !stall)
			first_reg <= 1'b0;
	end

	// ****************************************************************
	// Result routing
	// ****************************************************************

	logic                  pend_valid_reg;
	logic [`CTM_CNT_W-1:0] pend_data_reg;
	logic                  latest_ok_reg;
	logic [`CTM_CNT_W-1:0] latest_reg;
	logic                  want_reg;
	logic                  push;
	logic [`CTM_CNT_W-1:0] push_val;
	logic                  fifo_in_ready;
	logic                  time_mode;

	assign time_mode = (i_cfg.mode == ctm_pkg::MODE_ONE_CTR_TIME) ||
		(i_cfg.mode == ctm_pkg::MODE_TWO_CTR_TIME) ||
		(i_cfg.mode == ctm_pkg::MODE_TWO_EDGE_SEP);
	// Back-pressure from a full buffer freezes the counting core.
	assign stall = pend_valid_reg & ~fifo_in_ready;

	// Choose which event feeds the buffer in each timing type.
	always_comb
	begin
		push = 1'b0;
		push_val = meas_val;
		if (i_arm && !stall)
		begin
			if (i_cfg.mode == ctm_pkg::MODE_EDGE_BUF)
				push = mark;
			else if (time_mode && i_cfg.timing == ctm_pkg::TIMING_IMPLICIT)
				push = mark;
			else if (i_cfg.timing == ctm_pkg::TIMING_SAMPLE_CLK)
			begin
				// Sample clock decides the rate, input cycles are only tracked.
				push = smp_rise && (time_mode ? latest_ok_reg : i_cfg.mode == ctm_pkg::MODE_POSITION);
				push_val = time_mode ? latest_reg : cnt_reg;
			end
		end
	end

	// Latest complete interval kept for the sample clock.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !i_arm)
		begin
			latest_ok_reg <= 1'b0;
			latest_reg <= `CTM_ZERO_CNT;
		end
		else if (mark && !first_reg && !stall)
		begin
			latest_ok_reg <= 1'b1;
			latest_reg <= meas_val;
		end
	end

	// One holding slot in front of the buffer.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			pend_valid_reg <= 1'b0;
			pend_data_reg <= `CTM_ZERO_CNT;
		end
		else
		begin
			pend_valid_reg <= push | (pend_valid_reg & ~fifo_in_ready);
			if (push)
				pend_data_reg <= push_val;
		end
	end

	ctm_fifo #(.WIDTH(`CTM_CNT_W), .DEPTH(`CTM_FIFO_DEPTH)) u_fifo (
		.i_clk      (i_clk),
		.i_sys_rst  (i_sys_rst),
		.i_in_valid (pend_valid_reg),
		.o_in_ready (fifo_in_ready),
		.i_in_data  (pend_data_reg),
		.o_out_valid(o_res_valid),
		.i_out_ready(i_res_ready),
		.o_out_data (o_res_data)
	);

	// On-demand read: wait for the next full interval, or return the count.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || !i_arm)
		begin
			want_reg <= 1'b0;
			o_read_valid <= 1'b0;
			o_read_data <= `CTM_ZERO_CNT;
		end
		else
		begin
			o_read_valid <= 1'b0;
			if (demand && i_read_req)
			begin
				want_reg <= time_mode;
				if (!time_mode)
				begin
					o_read_valid <= 1'b1;
					o_read_data <= cnt_reg;
				end
			end
			else if (want_reg && mark && !first_reg && !stall)
			begin
				want_reg <= 1'b0;
				o_read_valid <= 1'b1;
				o_read_data <= meas_val;
			end
		end
	end

	assign o_count = cnt_reg;

	// ****************************************************************
	// Event output and connector pin
	// ****************************************************************

	logic routed_reg;

	// Pulse for one cycle or invert on terminal count.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			o_counter_event_output <= 1'b0;
		else if (i_cfg.out_toggle)
			o_counter_event_output <= o_counter_event_output ^ (tc & ~stall & i_arm);
		else
			o_counter_event_output <= tc & ~stall & i_arm;
	end

	// Route sticks until reset or tristate; pulse generation routes itself.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || i_tristate)
			routed_reg <= 1'b0;
		else if (i_export || (i_arm && i_cfg.mode == ctm_pkg::MODE_PULSE_GEN))
			routed_reg <= 1'b1;
	end

	assign o_connector_counter_pin = o_counter_event_output;
	assign o_connector_counter_pin_oe = routed_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************

	a_reset_state: assert property (@(posedge i_clk) i_sys_rst |=>
		cnt_reg == `CTM_ZERO_CNT && !o_connector_counter_pin_oe)
		else $error("reset left count or pin active");

	a_pin_stays: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		routed_reg && !i_tristate |=> o_connector_counter_pin_oe)
		else $error("routed pin dropped without tristate");

	a_event_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tc && i_arm && !stall && !i_cfg.out_toggle |=> o_counter_event_output)
		else $error("terminal count gave no pulse");

	a_event_toggle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		tc && i_arm && !stall && i_cfg.out_toggle |=>
		o_counter_event_output != $past(o_counter_event_output))
		else $error("terminal count gave no toggle");

	a_down_floor: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_arm && i_cfg.mode == ctm_pkg::MODE_EDGE_UNBUF && i_cfg.dir_from_aux &&
		!aux_lvl && cnt_reg == `CTM_ZERO_CNT ##1 i_arm |-> cnt_reg == `CTM_ZERO_CNT)
		else $error("down count passed zero");

	a_up_rollover: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_arm && !stall && i_cfg.mode == ctm_pkg::MODE_EDGE_UNBUF && tc |=>
		cnt_reg == `CTM_ZERO_CNT)
		else $error("rollover terminal count without wrap");

	a_gate_pause: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_arm && $past(i_arm) && i_cfg.mode == ctm_pkg::MODE_EDGE_UNBUF && !$past(gate_lvl)
		&& !$past(i_read_req) |-> cnt_reg == $past(cnt_reg))
		else $error("count moved while paused");

	a_implicit_push: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_arm && !stall && mark && time_mode && i_cfg.timing == ctm_pkg::TIMING_IMPLICIT
		|=> pend_valid_reg && pend_data_reg == $past(meas_val))
		else $error("interval not stored");

	a_sample_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_arm && !stall && smp_rise && time_mode && latest_ok_reg &&
		i_cfg.timing == ctm_pkg::TIMING_SAMPLE_CLK |=> pend_data_reg == $past(latest_reg))
		else $error("sample edge did not store latest");

	a_demand_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_read_valid && time_mode |-> $past(want_reg) && !$past(first_reg))
		else $error("read answered with partial interval");

endmodule

`default_nettype wire

// file: dv/ctm_ext_model.sv
// Model of the external digital signals around the counter.
`timescale 1ns/1ps
`default_nettype none

module ctm_ext_model (
	input  wire logic i_clk,
	output logic      o_gate,
	output logic      o_edge,
	output logic      o_aux,
	output logic      o_smp
);
	// ****************************************
	// Pin levels: 0 control, 1 edge, 2 sample, 3 auxiliary.
	// ****************************************
	logic [3:0] lv;

	// The pins are plain pushed levels with no release state.
	assign o_gate = lv[0];
	assign o_edge = lv[1];
	assign o_smp  = lv[2];
	assign o_aux  = lv[3];

	// All pins start low.
	initial
	begin
		lv = 4'h0;
	end

	// Levels change only off the sampling edge of the design clock.
	task automatic set_pin(input int sel, input logic v);
		@(negedge i_clk);
		lv[sel] = v;
	endtask

	// Four clocks per level, so the agreement filter never merges two edges.
	// The host picks the clock as timebase; the model only paces the pins.
	task automatic pulse(input int sel, input int n);
		repeat (n)
		begin
			set_pin(sel, 1'b1);
			repeat (3) @(negedge i_clk);
			set_pin(sel, 1'b0);
			repeat (3) @(negedge i_clk);
		end
	endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the counter time measurement block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	// ****************************************
	// Signals
	// ****************************************
	logic              i_clk;
	logic              i_sys_rst;
	ctm_pkg::ctm_cfg_t cfg;
	logic              arm, exp_req, tri_req, rd_req, res_ready;
	wire logic         gate, edg, aux, smp;
	logic [23:0]       count, rd_data, res_data, rd_last;
	logic              ev, pin, pin_oe, rd_valid, res_valid;
	int                errors, cmp_count, ev_cnt, pin_cnt;
	logic [23:0]       q[$];
	logic [2:0]        xf;

	ctm_top ctm_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg(cfg), .i_arm(arm),
		.i_export(exp_req), .i_tristate(tri_req), .i_read_req(rd_req),
		.i_count_control_input(gate), .i_count_edge_input(edg),
		.i_auxiliary_count_input(aux), .i_sample_clock_input(smp), .o_count(count),
		.o_counter_event_output(ev), .o_connector_counter_pin(pin),
		.o_connector_counter_pin_oe(pin_oe), .o_read_valid(rd_valid), .o_read_data(rd_data),
		.o_res_valid(res_valid), .i_res_ready(res_ready), .o_res_data(res_data));

	ctm_ext_model ctm_ext_model_inst (.i_clk(i_clk), .o_gate(gate), .o_edge(edg), .o_aux(aux),
		.o_smp(smp));

	// Free-running 200 MHz clock.
	initial i_clk = 1'b0;
	always #2.5 i_clk = ~i_clk;

	// Counts event pulses, pops results and keeps the last read word.
	always @(posedge i_clk)
	begin
		if (ev === 1'b1)
			ev_cnt++;
		if (pin === 1'b1 && pin_oe === 1'b1)
			pin_cnt++;
		if (res_valid === 1'b1 && res_ready === 1'b1)
			q.push_back(res_data);
		if (rd_valid === 1'b1)
			rd_last <= rd_data;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic complete_run();
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	// Disarming preloads the count, so every setup starts from a known value.
	// fl holds pulse_train, dir_from_aux and large_range.
	// xf holds out_toggle, gate_start and z_enable.
	task automatic start(input ctm_pkg::ctm_mode_t m, input ctm_pkg::ctm_timing_t t,
		input logic [23:0] ld, input logic [2:0] fl);
		@(negedge i_clk);
		arm = 1'b0;
		cfg = '{mode: m, timing: t, pulse_train: fl[2], out_toggle: xf[2], gate_start: xf[1],
			dir_from_aux: fl[1], z_enable: xf[0], large_range: fl[0], div_log2: 4'h1, load: ld};
		idle(2);
		arm = 1'b1;
		idle(2);
		q.delete();
		ev_cnt = 0;
		pin_cnt = 0;
	endtask

	// One-cycle request pulse on a control input.
	task automatic strobe(ref logic s);
		s = 1'b1;
		idle(1);
		s = 1'b0;
	endtask

	// A hang counts as a mismatch and ends the run the usual way.
	initial
	begin
		#200000;
		errors++;
		complete_run();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		{errors, cmp_count, ev_cnt, pin_cnt} = '0;
		xf = 3'h0;
		{arm, exp_req, tri_req, rd_req, res_ready} = '0;
		cfg = '0;
		i_sys_rst = 1'b1;
		idle(3);
		i_sys_rst = 1'b0;
		chk("reset count", 24'h000000, count);
		chk("reset oe", 24'h000000, {23'h0, pin_oe});
		res_ready = 1'b1;
		// Pulse generation: single pulse, then a train, with pin routing.
		ctm_ext_model_inst.set_pin(0, 1'b1);
		start(ctm_pkg::MODE_PULSE_GEN, ctm_pkg::TIMING_IMPLICIT, 24'h000001, 3'b000);
		ctm_ext_model_inst.pulse(1, 4);
		chk("single pulse", 24'h000001, ev_cnt[23:0]);
		start(ctm_pkg::MODE_PULSE_GEN, ctm_pkg::TIMING_IMPLICIT, 24'h000002, 3'b100);
		chk("routed oe", 24'h000001, {23'h0, pin_oe});
		ctm_ext_model_inst.pulse(1, 6);
		chk("train pulses", 24'h000002, ev_cnt[23:0]);
		chk("pin pulses", 24'h000002, pin_cnt[23:0]);
		// Armed pulse generation routes itself again, so disarm before the tristate.
		arm = 1'b0;
		strobe(tri_req);
		idle(2);
		chk("tristate oe", 24'h000000, {23'h0, pin_oe});
		strobe(exp_req);
		// Edge counting under the pause trigger, direction from the auxiliary pin.
		ctm_ext_model_inst.set_pin(3, 1'b1);
		start(ctm_pkg::MODE_EDGE_UNBUF, ctm_pkg::TIMING_IMPLICIT, 24'h000005, 3'b010);
		chk("sticky oe", 24'h000001, {23'h0, pin_oe});
		chk("preload", 24'h000005, count);
		ctm_ext_model_inst.pulse(1, 5);
		chk("count up", 24'h00000A, count);
		ctm_ext_model_inst.set_pin(0, 1'b0);
		ctm_ext_model_inst.pulse(1, 2);
		chk("paused", 24'h00000A, count);
		ctm_ext_model_inst.set_pin(0, 1'b1);
		ctm_ext_model_inst.set_pin(3, 1'b0);
		ctm_ext_model_inst.pulse(1, 12);
		chk("down stop", 24'h000000, count);
		chk("down tc", 24'h000001, ev_cnt[23:0]);
		start(ctm_pkg::MODE_EDGE_UNBUF, ctm_pkg::TIMING_IMPLICIT, 24'hFFFFFE, 3'b000);
		ctm_ext_model_inst.pulse(1, 2);
		chk("rollover", 24'h000000, count);
		chk("up tc", 24'h000001, ev_cnt[23:0]);
		// Toggle behaviour: the event output inverts and holds at terminal count.
		xf = 3'b100;
		start(ctm_pkg::MODE_EDGE_UNBUF, ctm_pkg::TIMING_IMPLICIT, 24'hFFFFFE, 3'b000);
		ctm_ext_model_inst.pulse(1, 2);
		chk("toggle level", 24'h000001, {23'h0, ev});
		xf = 3'b000;
		// Buffered edge counting: the control input samples the count.
		ctm_ext_model_inst.set_pin(0, 1'b0);
		start(ctm_pkg::MODE_EDGE_BUF, ctm_pkg::TIMING_IMPLICIT, 24'h000000, 3'b000);
		ctm_ext_model_inst.pulse(1, 3);
		ctm_ext_model_inst.pulse(0, 1);
		idle(4);
		chk("buffered count", 24'h000003, q[$]);
		// Fill the buffer while the reader stalls, then drain it.
		res_ready = 1'b0;
		start(ctm_pkg::MODE_EDGE_BUF, ctm_pkg::TIMING_IMPLICIT, 24'h000000, 3'b000);
		ctm_ext_model_inst.pulse(0, 18);
		chk("full valid", 24'h000001, {23'h0, res_valid});
		res_ready = 1'b1;
		idle(24);
		chk("drained", 24'h000011, q.size());
		// Implicit one-counter timing: every interval stored, first may be partial.
		start(ctm_pkg::MODE_ONE_CTR_TIME, ctm_pkg::TIMING_IMPLICIT, 24'h000000, 3'b000);
		ctm_ext_model_inst.pulse(1, 2);
		repeat (2)
		begin
			ctm_ext_model_inst.pulse(0, 1);
			ctm_ext_model_inst.pulse(1, 4);
		end
		ctm_ext_model_inst.pulse(0, 1);
		idle(4);
		chk("interval last", 24'h000004, q[$]);
		chk("interval prior", 24'h000004, q[q.size()-2]);
		chk("interval first", 24'h000002, q[0]);
		// Sample-clock timing: nothing stored until the sample edge.
		start(ctm_pkg::MODE_ONE_CTR_TIME, ctm_pkg::TIMING_SAMPLE_CLK, 24'h000000, 3'b000);
		ctm_ext_model_inst.pulse(0, 1);
		ctm_ext_model_inst.pulse(1, 4);
		ctm_ext_model_inst.pulse(0, 1);
		ctm_ext_model_inst.pulse(1, 2);
		chk("no store", 24'h000000, q.size());
		ctm_ext_model_inst.pulse(2, 1);
		idle(4);
		chk("sampled", 24'h000004, q[$]);
		// On-demand read discards the partial interval.
		start(ctm_pkg::MODE_ONE_CTR_TIME, ctm_pkg::TIMING_ON_DEMAND, 24'h000000, 3'b000);
		strobe(rd_req);
		ctm_ext_model_inst.pulse(0, 1);
		ctm_ext_model_inst.pulse(1, 3);
		ctm_ext_model_inst.pulse(0, 1);
		idle(4);
		chk("read data", 24'h000003, rd_last);
		// Large-range two-counter: 16 clocks over two edges, reported halved.
		start(ctm_pkg::MODE_TWO_CTR_TIME, ctm_pkg::TIMING_IMPLICIT, 24'h000000, 3'b001);
		ctm_ext_model_inst.pulse(1, 8);
		chk("divided period", 24'h000001, {23'h0, q[$] >= 24'h7 && q[$] <= 24'h9});
		// Position: auxiliary low steps up, high steps down, index zeroes.
		xf = 3'b001;
		start(ctm_pkg::MODE_POSITION, ctm_pkg::TIMING_ON_DEMAND, 24'h000000, 3'b000);
		ctm_ext_model_inst.pulse(1, 3);
		ctm_ext_model_inst.set_pin(3, 1'b1);
		ctm_ext_model_inst.pulse(1, 1);
		chk("position", 24'h000002, count);
		ctm_ext_model_inst.pulse(0, 1);
		chk("index zero", 24'h000000, count);
		// Start trigger: nothing counts until the control input rises once.
		xf = 3'b010;
		start(ctm_pkg::MODE_PULSE_GEN, ctm_pkg::TIMING_IMPLICIT, 24'h000001, 3'b000);
		ctm_ext_model_inst.pulse(1, 2);
		chk("not started", 24'h000000, ev_cnt[23:0]);
		ctm_ext_model_inst.pulse(0, 1);
		ctm_ext_model_inst.pulse(1, 2);
		chk("start trigger", 24'h000001, ev_cnt[23:0]);
		// Two-edge separation: auxiliary opens, edge input times, control closes.
		xf = 3'b000;
		ctm_ext_model_inst.set_pin(3, 1'b0);
		start(ctm_pkg::MODE_TWO_EDGE_SEP, ctm_pkg::TIMING_IMPLICIT, 24'h000000, 3'b000);
		ctm_ext_model_inst.pulse(3, 1);
		ctm_ext_model_inst.pulse(1, 3);
		ctm_ext_model_inst.pulse(0, 1);
		idle(4);
		chk("separation", 24'h000003, q[$]);
		complete_run();
	end
endmodule
`default_nettype wire
